// *** mor_regs.sv ***
// Operational register set: indirect port, timer, program counter, status, ports
`timescale 1ns/10ps
`include "mor_consts.svh"

module mor_regs
(
  input  wire logic             clk_sys_i,              // 100 MHz core clock
  input  wire logic             reset_i,                // Power-on reset, async, high
  input  wire logic             sys_reset_n_i,          // Reset pin, low active
  input  wire mor_pkg::mor_addr_t addr_i,               // Register offset
  input  wire mor_pkg::mor_byte_t wdata_i,              // Write data
  input  wire logic             wr_i,                   // Write strobe
  input  wire logic             rd_i,                   // Read strobe
  output logic [7:0]            rdata_o,                // Read data, cycle after rd_i
  output logic [7:0]            dmem_addr_o,            // Indirect data memory address
  output logic [7:0]            dmem_wdata_o,           // Indirect write data
  output logic                  dmem_we_o,              // Indirect write pulse
  output logic                  dmem_re_o,              // Indirect read pulse
  input  wire logic [7:0]       dmem_rdata_i,           // Indirect read data, same cycle
  input  wire logic             tcc_src_sel_i,          // 1: low-frequency tick source
  input  wire logic             lf_tick_i,              // 16.384KHz or RC/2 enable pulse
  input  wire logic             instr_tick_i,           // Instruction cycle enable pulse
  input  wire logic             pc_step_i,              // Plain sequential advance
  input  wire logic             jump_instr_i,           // Jump
  input  wire logic             call_instr_i,           // Call
  input  wire logic             return_instr_i,         // Any return variant
  input  wire logic             mov_pc_instr_i,         // Move accumulator into counter
  input  wire logic             add_pc_instr_i,         // Add accumulator to counter
  input  wire logic             table_instr_i,          // Table add
  input  wire logic [9:0]       jump_target_i,          // Instruction address field
  input  wire logic [7:0]       acc_i,                  // Accumulator
  input  wire logic             flags_we_i,             // ALU flag update
  input  wire logic [2:0]       flags_i,                // Zero, half carry, carry
  input  wire logic             sleep_instr_i,          // Sleep executed
  input  wire logic             watchdog_clear_instr_i, // Watchdog clear executed
  input  wire logic             watchdog_timer_timeout_i, // Watchdog expired
  output mor_pkg::mor_pc_t      pc_o,                   // Program counter
  output logic                  io_page_o,              // IO control page select
  output logic [3:0]            port5_o,                // Port-5 data
  output logic                  port_six_bit_o,         // Port-6 data
  output logic [7:0]            port7_o,                // Port-7 data
  output logic [7:0]            port8_o,                // Port-8 data
  output logic [7:0]            port9_o                 // Port-9 data
);
  import mor_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  mor_byte_t  timer_reg;                         // Timer/counter
  mor_pc_t    pc_reg;                            // Program counter
  mor_pc_t    stack_reg [`MOR_STACK_DEPTH];      // Hardware stack, entry 0 on top
  logic [2:0] flags_reg;                         // Zero, half carry, carry
  logic       pdown_reg;                         // Power-down indicator
  logic       tout_reg;                          // Time-out indicator
  logic       page_reg;                          // IO page select
  mor_byte_t  bank_sel_reg;                      // Bank and indirect index
  logic [3:0] page_bits_reg;                     // Program page
  logic [3:0] port5_reg;                         // Port-5 data nibble
  logic       port6_reg;                         // Port-6 data bit
  mor_byte_t  port7_reg;                         // Port-7 data
  mor_byte_t  port8_reg;                         // Port-8 data
  mor_byte_t  port9_reg;                         // Port-9 data
  mor_byte_t  rdata_reg;                         // Read data holding
  mor_byte_t  rd_next;                           // Read mux
  mor_pc_t    pc_next;                           // Next counter
  logic       run;                               // Reset pin released
  logic       op_jump, op_call, op_ret;          // Prioritised counter ops
  logic       op_mov, op_add, op_tbl;
  logic [7:0] rel_low;                           // Relative low byte

  assign run = sys_reset_n_i;

  // Software write decode
  function automatic logic wr_at(input mor_addr_t a);
    wr_at = wr_i && (addr_i == a);
  endfunction : wr_at

  // ==========================================================================
  // Indirect access
  // ==========================================================================
  // The location has no storage; the bank select register is the address
  assign dmem_addr_o  = bank_sel_reg;
  assign dmem_wdata_o = wdata_i;
  assign dmem_we_o    = run && wr_at(`MOR_OFF_INDIRECT);
  assign dmem_re_o    = run && rd_i && (addr_i == `MOR_OFF_INDIRECT);

  // ==========================================================================
  // Timer/counter
  // ==========================================================================
  // A software write wins over a tick in the same cycle
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      timer_reg <= `MOR_RST_BYTE;
    else if (!run)
      timer_reg <= `MOR_RST_BYTE;
    else if (wr_at(`MOR_OFF_TIMER))
      timer_reg <= wdata_i;
    else if (tcc_src_sel_i ? lf_tick_i : instr_tick_i)
      timer_reg <= timer_reg + 8'h01;
  end

  // ==========================================================================
  // Program counter and stack
  // ==========================================================================
  // One counter operation per cycle; software write to the low byte acts as
  // an accumulator move
  always_comb
  begin
    op_jump = jump_instr_i;
    op_call = !op_jump && call_instr_i;
    op_ret  = !op_jump && !op_call && return_instr_i;
    op_mov  = !op_jump && !op_call && !op_ret && mov_pc_instr_i;
    op_add  = !op_jump && !op_call && !op_ret && !op_mov && add_pc_instr_i;
    op_tbl  = !op_jump && !op_call && !op_ret && !op_mov && !op_add && table_instr_i;
  end

  assign rel_low = pc_reg[7:0] + acc_i;

  // Counter next value
  always_comb
  begin
    pc_next = pc_reg;
    if (op_jump || op_call)
      pc_next = {page_bits_reg, jump_target_i};
    else if (op_ret)
      pc_next = stack_reg[0];
    else if (op_mov)
      pc_next = {page_bits_reg, 2'b00, acc_i};
    else if (op_add)
      pc_next = {page_bits_reg, 2'b00, rel_low};
    else if (op_tbl)
      pc_next = {page_bits_reg, pc_reg[9:8], rel_low};
    else if (wr_at(`MOR_OFF_PC_LOW))
      pc_next = {page_bits_reg, 2'b00, wdata_i};
    else if (pc_step_i)
      pc_next = pc_reg + 14'h0001;
  end

  // Counter register
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      pc_reg <= `MOR_RST_PC;
    else if (!run)
      pc_reg <= `MOR_RST_PC;
    else
      pc_reg <= pc_next;
  end

  // Stack shifts as a whole; overflow drops the oldest entry silently
  genvar gi;
  generate
    for (gi = 0; gi < `MOR_STACK_DEPTH; gi++)
    begin : g_stack
      always_ff @(posedge clk_sys_i or posedge reset_i)
      begin
        if (reset_i)
          stack_reg[gi] <= `MOR_RST_PC;
        else if (run && op_call)
          stack_reg[gi] <= (gi == 0) ? pc_reg + 14'h0001 : stack_reg[(gi == 0) ? 0 : gi - 1];
        else if (run && op_ret)
          stack_reg[gi] <= (gi == `MOR_STACK_DEPTH - 1) ? `MOR_RST_PC
                           : stack_reg[(gi == `MOR_STACK_DEPTH - 1) ? gi : gi + 1];
      end
    end
  endgenerate

  // ==========================================================================
  // Status
  // ==========================================================================
  // ALU update overrides a software write to the same flags
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      flags_reg <= `MOR_RST_FLAGS;
      page_reg  <= 1'b0;
    end
    else if (!run)
    begin
      flags_reg <= `MOR_RST_FLAGS;
      page_reg  <= 1'b0;
    end
    else
    begin
      if (flags_we_i)
        flags_reg <= flags_i;
      else if (wr_at(`MOR_OFF_STATUS))
        flags_reg <= wdata_i[`MOR_ST_ZERO:`MOR_ST_CARRY];
      if (wr_at(`MOR_OFF_STATUS))
        page_reg <= wdata_i[`MOR_ST_PAGE];
    end
  end

  // Indicators are untouched by the reset pin so that they record the wake
  // cause; of the two resets only power-on sets them. Set wins over clear.
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pdown_reg <= 1'b1;
      tout_reg  <= 1'b1;
    end
    else
    begin
      if (watchdog_clear_instr_i)
        pdown_reg <= 1'b1;
      else if (sleep_instr_i)
        pdown_reg <= 1'b0;
      if (sleep_instr_i || watchdog_clear_instr_i)
        tout_reg <= 1'b1;
      else if (watchdog_timer_timeout_i)
        tout_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Bank select, page select and ports
  // ==========================================================================
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bank_sel_reg  <= `MOR_RST_BYTE;
      page_bits_reg <= `MOR_RST_NIBBLE;
      port5_reg     <= `MOR_RST_NIBBLE;
      port6_reg     <= 1'b0;
      port7_reg     <= `MOR_RST_BYTE;
      port8_reg     <= `MOR_RST_BYTE;
      port9_reg     <= `MOR_RST_BYTE;
    end
    else if (!run)
    begin
      bank_sel_reg  <= `MOR_RST_BYTE;
      page_bits_reg <= `MOR_RST_NIBBLE;
      port5_reg     <= `MOR_RST_NIBBLE;
      port6_reg     <= 1'b0;
      port7_reg     <= `MOR_RST_BYTE;
      port8_reg     <= `MOR_RST_BYTE;
      port9_reg     <= `MOR_RST_BYTE;
    end
    else
    begin
      if (wr_at(`MOR_OFF_BANK_SEL))
        bank_sel_reg <= wdata_i;
      if (wr_at(`MOR_OFF_PAGE_SEL))
      begin
        page_bits_reg <= wdata_i[3:0];
        port5_reg     <= wdata_i[7:4];
      end
      if (wr_at(`MOR_OFF_PORT6))
        port6_reg <= wdata_i[0];
      if (wr_at(`MOR_OFF_PORT7))
        port7_reg <= wdata_i;
      if (wr_at(`MOR_OFF_PORT8))
        port8_reg <= wdata_i;
      if (wr_at(`MOR_OFF_PORT9))
        port9_reg <= wdata_i;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb
  begin
    rd_next = 8'h00;
    unique case (addr_i)
      `MOR_OFF_INDIRECT: rd_next = dmem_rdata_i;
      `MOR_OFF_TIMER:    rd_next = timer_reg;
      `MOR_OFF_PC_LOW:   rd_next = pc_reg[7:0];
      `MOR_OFF_STATUS:   rd_next = {1'b0, page_reg, 1'b0, tout_reg, pdown_reg, flags_reg};
      `MOR_OFF_BANK_SEL: rd_next = bank_sel_reg;
      `MOR_OFF_PAGE_SEL: rd_next = {port5_reg, page_bits_reg};
      `MOR_OFF_PORT6:    rd_next = {7'h00, port6_reg};
      `MOR_OFF_PORT7:    rd_next = port7_reg;
      `MOR_OFF_PORT8:    rd_next = port8_reg;
      `MOR_OFF_PORT9:    rd_next = port9_reg;
      default:           rd_next = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_reg <= `MOR_RST_BYTE;
    else
      rdata_reg <= (rd_i && run) ? rd_next : 8'h00;
  end

  assign rdata_o        = rdata_reg;
  assign pc_o           = pc_reg;
  assign io_page_o      = page_reg;
  assign port5_o        = port5_reg;
  assign port_six_bit_o = port6_reg;
  assign port7_o        = port7_reg;
  assign port8_o        = port8_reg;
  assign port9_o        = port9_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_call_taken;
    run && op_call;
  endsequence

  sequence s_ret_taken;
    run && op_ret;
  endsequence

  property p_timer_tick;
    run && !wr_at(`MOR_OFF_TIMER) && !tcc_src_sel_i && instr_tick_i
      |=> timer_reg == 8'($past(timer_reg) + 8'h01);
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("timer missed tick");

  property p_jump;
    run && op_jump |=> pc_reg == {$past(page_bits_reg), $past(jump_target_i)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_call_ret;
    s_call_taken ##1 s_ret_taken |=> pc_reg == 14'($past(pc_reg, 2) + 14'h0001);
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("return address wrong");

  property p_ret;
    s_ret_taken |=> pc_reg == $past(stack_reg[0]);
  endproperty
  a_ret: assert property (p_ret) else $error("return not from stack");

  property p_mov;
    run && op_mov |=> pc_reg[9:8] == 2'b00 && pc_reg[7:0] == $past(acc_i);
  endproperty
  a_mov: assert property (p_mov) else $error("move into counter wrong");

  property p_tbl;
    run && op_tbl |=> pc_reg[9:8] == $past(pc_reg[9:8]) && pc_reg[13:10] == $past(page_bits_reg);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table add wrong");

  property p_sleep;
    sleep_instr_i && !watchdog_clear_instr_i ##1 watchdog_timer_timeout_i && !sleep_instr_i
      && !watchdog_clear_instr_i |=> !tout_reg && !pdown_reg;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep wake pair wrong");

  property p_status_read;
    rd_i && run && addr_i == `MOR_OFF_STATUS
      |=> rdata_o[`MOR_ST_ZERO5] == 1'b0 && rdata_o[`MOR_ST_PAGE] == io_page_o;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_unmapped;
    rd_i && addr_i > `MOR_OFF_PORT9 |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule : mor_regs

// *** mor_consts.svh ***
// Offsets, field positions and reset values of the operational register set
`ifndef MOR_CONSTS_SVH
`define MOR_CONSTS_SVH
// Register offsets on the software port
`define MOR_OFF_INDIRECT 4'h0
`define MOR_OFF_TIMER    4'h1
`define MOR_OFF_PC_LOW   4'h2
`define MOR_OFF_STATUS   4'h3
`define MOR_OFF_BANK_SEL 4'h4
`define MOR_OFF_PAGE_SEL 4'h5
`define MOR_OFF_PORT6    4'h6
`define MOR_OFF_PORT7    4'h7
`define MOR_OFF_PORT8    4'h8
`define MOR_OFF_PORT9    4'h9
// Status field positions
`define MOR_ST_CARRY     0
`define MOR_ST_HALF      1
`define MOR_ST_ZERO      2
`define MOR_ST_PDOWN     3
`define MOR_ST_TOUT      4
`define MOR_ST_ZERO5     5
`define MOR_ST_PAGE      6
// Stack depth and reset values
`define MOR_STACK_DEPTH  8
`define MOR_RST_BYTE     8'h00
`define MOR_RST_PC       14'h0000
`define MOR_RST_NIBBLE   4'h0
`define MOR_RST_FLAGS    3'h0
`endif

// *** mor_pkg.sv ***
// Types shared by the operational register set
package mor_pkg;
  typedef logic [13:0] mor_pc_t;    // Program counter / stack word
  typedef logic [3:0]  mor_addr_t;  // Register offset
  typedef logic [7:0]  mor_byte_t;  // Register data
endpackage : mor_pkg

// *** mor_regs_bench.sv ***
// Self-checking bench for the operational register set
`timescale 1ns/10ps
`include "mor_consts.svh"

module mor_regs_bench;
  import mor_pkg::*;
  // ======================================================================
  // Signals around the design
  logic        clk_sys_i, reset_i, sys_reset_n_i; // Clock, power-on reset, reset pin
  mor_addr_t   addr_i;                            // Register offset
  mor_byte_t   wdata_i;                           // Write data
  logic        wr_i, rd_i;                        // Bus strobes
  logic [7:0]  rdata_o, dmem_addr_o, dmem_wdata_o; // Read data, indirect address and data
  logic        dmem_we_o, dmem_re_o;              // Indirect strobes
  logic [7:0]  dmem_rdata_i, acc_i;               // Data memory answer, accumulator
  logic        tcc_src_sel_i;                     // Timer source select
  logic [12:0] strb;                              // One-cycle instruction and tick pulses
  logic [9:0]  jump_target_i;                     // Address field
  logic [2:0]  flags_i;                           // Zero, half, carry
  mor_pc_t     pc_o;                              // Program counter
  logic        io_page_o, port_six_bit_o;         // Page bit, port-6 bit
  logic [3:0]  port5_o;                           // Port-5 data
  logic [7:0]  port7_o, port8_o, port9_o;         // Byte ports
  // Bench state
  int          err_count, check_count;            // Mismatches and comparisons
  logic [7:0]  v;                                 // Last value read
  logic        re_seen, we_seen;                  // Indirect strobes seen in the bus cycle
  logic        pg;                                // Expected page bit
  logic [2:0]  fl;                                // Expected flags
  logic [19:0] rows [9];                          // Offset, write data, read back
  logic [27:0] pcs [11];                          // Op code, operand, expected counter

  // ======================================================================
  // Design under test; strobes come from one vector so one task drives all
  mor_regs mor_regs_inst
  (
    .clk_sys_i, .reset_i, .sys_reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .dmem_addr_o, .dmem_wdata_o, .dmem_we_o, .dmem_re_o, .dmem_rdata_i, .tcc_src_sel_i,
    .lf_tick_i(strb[8]), .instr_tick_i(strb[7]), .pc_step_i(strb[6]),
    .jump_instr_i(strb[0]), .call_instr_i(strb[1]), .return_instr_i(strb[2]),
    .mov_pc_instr_i(strb[3]), .add_pc_instr_i(strb[4]), .table_instr_i(strb[5]),
    .jump_target_i, .acc_i, .flags_we_i(strb[9]), .flags_i, .sleep_instr_i(strb[10]),
    .watchdog_clear_instr_i(strb[11]), .watchdog_timer_timeout_i(strb[12]), .pc_o,
    .io_page_o, .port5_o, .port_six_bit_o, .port7_o, .port8_o, .port9_o
  );

  // ======================================================================
  // Clock: 100 MHz
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ======================================================================
  // Tasks
  // Compare and count; four-state equality so an unknown never matches
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // One-cycle bus write; the indirect strobe is sampled once inputs settle
  task automatic wr(input mor_addr_t a, input mor_byte_t d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    #1 we_seen = dmem_we_o;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // One-cycle bus read; data is only valid in the following cycle
  task automatic rd(input mor_addr_t a);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    #1 re_seen = dmem_re_o;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  // Pulse one strobe with its operand, then let the update land
  task automatic op(input int k, input logic [9:0] d);
    @(posedge clk_sys_i);
    jump_target_i <= d;
    acc_i         <= d[7:0];
    flags_i       <= d[2:0];
    strb[k]       <= 1'b1;
    @(posedge clk_sys_i);
    strb <= '0;
    #1;
  endtask : op

  // Status read against the expected page, time-out, power-down and flags
  task automatic st(input logic t, input logic p);
    rd(`MOR_OFF_STATUS);
    chk({16'h0000, v}, {16'h0000, 1'b0, pg, 1'b0, t, p, fl}, "status");
  endtask : st

  // Counts, then the verdict
  task automatic test_done;
    $display("Counts: %0d comparisons, %0d mismatches", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ======================================================================
  // Watchdog: all tests need well under 2000 cycles
  initial
  begin
    #50000;
    err_count++;
    $display("MISMATCH at %0t: run did not finish", $time);
    test_done();
  end

  // ======================================================================
  // Main sequence
  initial
  begin
    err_count = 0;
    check_count = 0;
    reset_i = 1'b1;
    sys_reset_n_i = 1'b1;
    {addr_i, wdata_i, wr_i, rd_i, strb, dmem_rdata_i} = '0;
    {tcc_src_sel_i, jump_target_i, acc_i, flags_i, pg, fl} = '0;
    // Status write: bits 7,5 read zero, time-out and power-down are read-only
    rows = '{{`MOR_OFF_TIMER, 16'ha5a5}, {`MOR_OFF_STATUS, 16'hff5f},
             {`MOR_OFF_BANK_SEL, 16'hc5c5}, {`MOR_OFF_PAGE_SEL, 16'ha3a3},
             {`MOR_OFF_PORT6, 16'hff01}, {`MOR_OFF_PORT7, 16'h3c3c},
             {`MOR_OFF_PORT8, 16'hc3c3}, {`MOR_OFF_PORT9, 16'h5a5a}, {4'ha, 16'hff00}};
    // Page 3 is selected by the table above, so the top counter bits read 0011, except after the last return (0100)
    pcs = '{{4'd0, 10'h155, 14'h0d55}, {4'd1, 10'h0aa, 14'h0caa}, {4'd2, 10'h000, 14'h0d56},
            {4'd3, 10'h0f0, 14'h0cf0}, {4'd0, 10'h3ff, 14'h0fff}, {4'd4, 10'h001, 14'h0c00},
            {4'd6, 10'h000, 14'h0c01}, {4'd0, 10'h3fe, 14'h0ffe}, {4'd5, 10'h001, 14'h0fff},
            {4'd1, 10'h200, 14'h0e00}, {4'd2, 10'h000, 14'h1000}};
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    st(1'b1, 1'b1);
    $display("test power-up done");
    // Ordinary register rows: write, read back
    foreach (rows[i])
    begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk({16'h0000, v}, {16'h0000, rows[i][7:0]}, "read back");
    end
    pg = 1'b1;
    fl = 3'b111;
    chk({10'h000, port5_o, port_six_bit_o, io_page_o, dmem_addr_o}, 24'h002bc5, "outs");
    chk({port7_o, port8_o, port9_o}, 24'h3cc35a, "ports");
    $display("test register rows done");
    // Indirect location forwards to data memory
    wr(`MOR_OFF_INDIRECT, 8'h77);
    chk({7'h00, we_seen, dmem_wdata_o, dmem_addr_o}, 24'h0177c5, "indirect write");
    @(posedge clk_sys_i);
    dmem_rdata_i <= 8'h9e;
    rd(`MOR_OFF_INDIRECT);
    chk({15'h0000, re_seen, v}, 24'h00019e, "indirect read");
    $display("test indirect done");
    // Timer: wraps, counts only the selected tick
    wr(`MOR_OFF_TIMER, 8'hfe);
    repeat (3) op(7, 10'h000);
    op(8, 10'h000);
    rd(`MOR_OFF_TIMER);
    chk({16'h0000, v}, 24'h000001, "timer instr tick");
    @(posedge clk_sys_i);
    tcc_src_sel_i <= 1'b1;
    op(8, 10'h000);
    op(8, 10'h000);
    op(7, 10'h000);
    rd(`MOR_OFF_TIMER);
    chk({16'h0000, v}, 24'h000003, "timer low tick");
    $display("test timer done");
    // Counter operations
    foreach (pcs[i])
    begin
      op(int'(pcs[i][27:24]), pcs[i][23:14]);
      chk({10'h000, pc_o}, {10'h000, pcs[i][13:0]}, "counter");
    end
    wr(`MOR_OFF_PC_LOW, 8'h12);
    #1 chk({10'h000, pc_o}, 24'h000c12, "counter bus write");
    // Call directly followed by return: the pushed counter plus one comes back
    @(posedge clk_sys_i);
    jump_target_i <= 10'h044;
    strb[1]       <= 1'b1;
    @(posedge clk_sys_i);
    strb          <= 13'h0004;
    @(posedge clk_sys_i);
    strb          <= '0;
    #1 chk({10'h000, pc_o}, 24'h000c13, "call then return");
    $display("test counter done");
    // Flags and the time-out/power-down pair
    op(9, 10'h005);
    fl = 3'b101;
    st(1'b1, 1'b1);
    op(10, 10'h000);
    st(1'b1, 1'b0);
    op(12, 10'h000);
    st(1'b0, 1'b0);
    op(11, 10'h000);
    st(1'b1, 1'b1);
    op(12, 10'h000);
    st(1'b0, 1'b1);
    // Sleep directly followed by a watchdog time-out: wake pair reads 0/0
    @(posedge clk_sys_i);
    strb <= 13'h0400;
    @(posedge clk_sys_i);
    strb <= 13'h1000;
    @(posedge clk_sys_i);
    strb <= '0;
    st(1'b0, 1'b0);
    op(10, 10'h000);
    $display("test status done");
    // Reset pin after sleep: keeps the pair, clears the rest, ignores writes
    @(posedge clk_sys_i);
    sys_reset_n_i <= 1'b0;
    wr(`MOR_OFF_PORT7, 8'hff);
    @(posedge clk_sys_i);
    sys_reset_n_i <= 1'b1;
    {pg, fl} = '0;
    st(1'b1, 1'b0);
    chk({port7_o, port9_o, 8'h00}, 24'h000000, "pin reset");
    chk({10'h000, pc_o}, 24'h000000, "pin reset counter");
    $display("test reset pin done");
    // Power-on reset in mid-run
    wr(`MOR_OFF_PORT9, 8'h66);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    st(1'b1, 1'b1);
    chk({16'h0000, port9_o}, 24'h000000, "power-on port");
    $display("test power-on again done");
    test_done();
  end
endmodule : mor_regs_bench
